// *** rtl/spm_pkg.sv ***
/*
 * constants, register map and shared helpers of the sensor power-mode controller.
 * assumes one 200 MHz clock and a register port driven by the serial slave logic.
 */
package spm_pkg;
    localparam int CLK_HZ = 200_000_000;
    localparam int TOP_RATE_HZ = 3200;
    localparam int TICK_3200_CYCLES = CLK_HZ / TOP_RATE_HZ;
    localparam logic [11:0] BASE_TICKS_PER_SEC = 12'(TOP_RATE_HZ);

    localparam logic [5:0] ADDR_INACT_THR = 6'h25;
    localparam logic [5:0] ADDR_INACT_PERIOD = 6'h26;
    localparam logic [5:0] ADDR_RATE_CTRL = 6'h2C;
    localparam logic [5:0] ADDR_POWER_CTRL = 6'h2D;
    localparam logic [5:0] ADDR_MODE_STATUS = 6'h3F;

    localparam int POW_LINK_BIT = 5;
    localparam int POW_AUTOSLEEP_BIT = 4;
    localparam int POW_MEASURE_BIT = 3;
    localparam int RATE_LOWPWR_BIT = 4;

    localparam logic [7:0] RST_INACT_THR = 8'h00;
    localparam logic [7:0] RST_INACT_PERIOD = 8'h00;
    localparam logic [4:0] RST_RATE_CTRL = 5'h0A;
    localparam logic [2:0] RST_POWER_CTRL = 3'h0;

    localparam logic [3:0] RATE_CODE_FASTEST = 4'hF;
    localparam logic [3:0] RATE_CODE_SLOWEST = 4'h6;
    localparam logic [3:0] SLEEP_RATE_CODE = 4'h6;

    localparam int ACCEL_W = 13;
    localparam int THR_SHIFT = 4;

    typedef enum logic [1:0] {
        SPM_STANDBY = 2'b00,
        SPM_MEASURE = 2'b01,
        SPM_SLEEP = 2'b10
    } spm_state_type;

    // base 3200 Hz ticks per output sample; codes below the slowest clamp to it
    function automatic logic [9:0] spm_base_per_sample(input logic [3:0] code);
        logic [3:0] c;
        c = (code < RATE_CODE_SLOWEST) ? RATE_CODE_SLOWEST : code;
        return 10'(10'h001 << (RATE_CODE_FASTEST - c));
    endfunction
endpackage

// *** rtl/spm_tb_if.sv ***
/*
 * link between the mode controller and its sample timebase.
 * assumes both ends run on i_mclk.
 */
`timescale 1ns/100ps
interface spm_tb_if;
    logic run;
    logic [3:0] rate_code;
    logic base_tick;
    logic sample_tick;
    modport ctrl (output run, output rate_code, input base_tick, input sample_tick);
    modport gen (input run, input rate_code, output base_tick, output sample_tick);
endinterface

// *** rtl/spm_timebase.sv ***
/*
 * sample timebase: 3200 Hz base enable and the output-rate sample enable.
 * assumes the controller changes the rate code on a sample tick, while stopped, or on waking from sleep.
 */
`timescale 1ns/100ps
module spm_timebase
    import spm_pkg::*;
#(
    parameter int P_TICK_3200_CYCLES = TICK_3200_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    spm_tb_if.gen tb
);
    if (P_TICK_3200_CYCLES < 2) begin : g_bad_div
        $error("base divider must be at least 2 cycles");
    end

    logic [31:0] div_cnt;
    logic [31:0] next_div_cnt;
    logic [9:0] sub_cnt;
    logic [9:0] next_sub_cnt;
    logic base_tick;
    logic next_base_tick;
    logic sample_tick;
    logic next_sample_tick;

    always_comb begin
        next_div_cnt = div_cnt;
        next_sub_cnt = sub_cnt;
        next_base_tick = 1'b0;
        next_sample_tick = 1'b0;
        if (!tb.run) begin
            // stopped counters restart aligned to the first sample after measure
            next_div_cnt = '0;
            next_sub_cnt = '0;
        end else if (div_cnt == 32'(P_TICK_3200_CYCLES - 1)) begin
            next_div_cnt = '0;
            next_base_tick = 1'b1;
            if (sub_cnt >= spm_base_per_sample(tb.rate_code) - 10'd1) begin
                next_sub_cnt = '0;
                next_sample_tick = 1'b1;
            end else begin
                next_sub_cnt = sub_cnt + 10'd1;
            end
        end else begin
            next_div_cnt = div_cnt + 32'd1;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            div_cnt <= '0;
            sub_cnt <= '0;
            base_tick <= 1'b0;
            sample_tick <= 1'b0;
        end else begin
            div_cnt <= next_div_cnt;
            sub_cnt <= next_sub_cnt;
            base_tick <= next_base_tick;
            sample_tick <= next_sample_tick;
        end
    end

    assign tb.base_tick = base_tick;
    assign tb.sample_tick = sample_tick;
endmodule

// *** rtl/spm_power_ctrl.sv ***
/*
 * power-mode controller: registers, standby/measure/sleep modes, rate select, autosleep.
 * assumes a register port from the serial slave on the same clock and
 * acceleration samples from the sensing chain, also on the same clock.
 */
`timescale 1ns/100ps
module spm_power_ctrl
    import spm_pkg::*;
#(
    parameter int P_TICK_3200_CYCLES = TICK_3200_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [5:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic i_accel_valid,
    input wire logic signed [ACCEL_W-1:0] i_accel_x,
    input wire logic signed [ACCEL_W-1:0] i_accel_y,
    input wire logic signed [ACCEL_W-1:0] i_accel_z,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic o_sensing_on,
    output logic o_sleep,
    output logic o_sample_strobe,
    output logic [3:0] o_rate_code,
    output logic o_low_power
);
    if (P_TICK_3200_CYCLES < 2) begin : g_bad_div
        $error("base divider must be at least 2 cycles");
    end

    spm_tb_if tb ();

    spm_timebase #(
        .P_TICK_3200_CYCLES(P_TICK_3200_CYCLES)
    ) u_timebase (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .tb(tb)
    );

    // magnitude of one axis above the threshold scale
    function automatic logic spm_over(input logic signed [ACCEL_W-1:0] a,
                                      input logic [7:0] thr);
        logic [ACCEL_W-1:0] mag;
        mag = a[ACCEL_W-1] ? ACCEL_W'(-a) : ACCEL_W'(a);
        return (mag >> THR_SHIFT) > ACCEL_W'(thr);
    endfunction

    // software-facing registers
    logic [7:0] inact_thr;
    logic [7:0] next_inact_thr;
    logic [7:0] inact_period;
    logic [7:0] next_inact_period;
    logic [4:0] rate_ctrl;
    logic [4:0] next_rate_ctrl;
    logic [2:0] pow_ctrl;
    logic [2:0] next_pow_ctrl;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic rvalid;
    logic next_rvalid;

    // values in force for the running sample
    logic [7:0] app_thr;
    logic [7:0] next_app_thr;
    logic [7:0] app_period;
    logic [7:0] next_app_period;
    logic [4:0] app_rate;
    logic [4:0] next_app_rate;

    // mode and inactivity state
    spm_state_type state;
    spm_state_type next_state;
    logic [8:0] quiet_secs;
    logic [8:0] next_quiet_secs;
    logic [11:0] sec_acc;
    logic [11:0] next_sec_acc;
    logic last_active;
    logic next_last_active;
    logic sensing_on;
    logic sleep_q;
    logic strobe_q;
    logic [3:0] rate_q;
    logic lowpwr_q;

    logic ctl_measure;
    logic auto_on;
    logic any_active;
    logic [11:0] acc_sum;

    assign ctl_measure = pow_ctrl[2];
    assign auto_on = pow_ctrl[1] & pow_ctrl[0];
    assign any_active = i_accel_valid &&
                        (spm_over(i_accel_x, app_thr) || spm_over(i_accel_y, app_thr) ||
                         spm_over(i_accel_z, app_thr));
    assign acc_sum = sec_acc + 12'(spm_base_per_sample(app_rate[3:0]));

    // registers stay open in every mode, standby included
    always_comb begin
        next_inact_thr = inact_thr;
        next_inact_period = inact_period;
        next_rate_ctrl = rate_ctrl;
        next_pow_ctrl = pow_ctrl;
        next_rdata = rdata;
        next_rvalid = i_reg_rd;
        if (i_reg_wr) begin
            case (i_reg_addr)
                ADDR_INACT_THR: next_inact_thr = i_reg_wdata;
                ADDR_INACT_PERIOD: next_inact_period = i_reg_wdata;
                ADDR_RATE_CTRL: next_rate_ctrl = i_reg_wdata[4:0];
                ADDR_POWER_CTRL: next_pow_ctrl = {i_reg_wdata[POW_MEASURE_BIT],
                                                  i_reg_wdata[POW_AUTOSLEEP_BIT],
                                                  i_reg_wdata[POW_LINK_BIT]};
                default: next_pow_ctrl = pow_ctrl;
            endcase
        end
        if (i_reg_rd) begin
            case (i_reg_addr)
                ADDR_INACT_THR: next_rdata = inact_thr;
                ADDR_INACT_PERIOD: next_rdata = inact_period;
                ADDR_RATE_CTRL: next_rdata = {3'h0, rate_ctrl};
                ADDR_POWER_CTRL: next_rdata = {2'h0, pow_ctrl[0], pow_ctrl[1],
                                               pow_ctrl[2], 3'h0};
                ADDR_MODE_STATUS: next_rdata = {5'h00, last_active, state};
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // settings move into force only between samples so none is split
    always_comb begin
        next_app_thr = app_thr;
        next_app_period = app_period;
        next_app_rate = app_rate;
        if (tb.sample_tick || state == SPM_STANDBY) begin
            next_app_thr = inact_thr;
            next_app_period = inact_period;
            next_app_rate = rate_ctrl;
        end
    end

    always_comb begin
        next_state = state;
        next_quiet_secs = quiet_secs;
        next_sec_acc = sec_acc;
        // samples are ignored in standby, where sensing is off
        next_last_active = (i_accel_valid && state != SPM_STANDBY) ? any_active : last_active;
        if (!ctl_measure) begin
            next_state = SPM_STANDBY;
            next_quiet_secs = '0;
            next_sec_acc = '0;
        end else begin
            case (state)
                SPM_STANDBY: begin
                    next_state = SPM_MEASURE;
                end
                SPM_MEASURE: begin
                    if (!auto_on || any_active) begin
                        next_quiet_secs = '0;
                        next_sec_acc = '0;
                    end else if (tb.sample_tick) begin
                        if (acc_sum >= BASE_TICKS_PER_SEC) begin
                            next_sec_acc = acc_sum - BASE_TICKS_PER_SEC;
                            next_quiet_secs = (quiet_secs == 9'h0FF) ? quiet_secs
                                                                     : quiet_secs + 9'd1;
                            if (app_period != 8'h00 &&
                                quiet_secs + 9'd1 >= {1'b0, app_period}) begin
                                next_state = SPM_SLEEP;
                                next_quiet_secs = '0;
                                next_sec_acc = '0;
                            end
                        end else begin
                            next_sec_acc = acc_sum;
                        end
                    end
                end
                SPM_SLEEP: begin
                    // activity or dropping autosleep wakes the device back to measuring
                    if (!auto_on || any_active) begin
                        next_state = SPM_MEASURE;
                    end
                end
                default: next_state = SPM_STANDBY;
            endcase
        end
    end

    // sleep samples slowly to watch for activity; standby stops the timebase entirely
    assign tb.run = (state != SPM_STANDBY);
    assign tb.rate_code = (state == SPM_SLEEP) ? SLEEP_RATE_CODE : app_rate[3:0];

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            inact_thr <= RST_INACT_THR;
            inact_period <= RST_INACT_PERIOD;
            rate_ctrl <= RST_RATE_CTRL;
            pow_ctrl <= RST_POWER_CTRL;
            rdata <= 8'h00;
            rvalid <= 1'b0;
            app_thr <= RST_INACT_THR;
            app_period <= RST_INACT_PERIOD;
            app_rate <= RST_RATE_CTRL;
            state <= SPM_STANDBY;
            quiet_secs <= '0;
            sec_acc <= '0;
            last_active <= 1'b0;
            sensing_on <= 1'b0;
            sleep_q <= 1'b0;
            strobe_q <= 1'b0;
            rate_q <= RST_RATE_CTRL[3:0];
            lowpwr_q <= 1'b0;
        end else begin
            inact_thr <= next_inact_thr;
            inact_period <= next_inact_period;
            rate_ctrl <= next_rate_ctrl;
            pow_ctrl <= next_pow_ctrl;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            app_thr <= next_app_thr;
            app_period <= next_app_period;
            app_rate <= next_app_rate;
            state <= next_state;
            quiet_secs <= next_quiet_secs;
            sec_acc <= next_sec_acc;
            last_active <= next_last_active;
            sensing_on <= (next_state != SPM_STANDBY);
            sleep_q <= (next_state == SPM_SLEEP);
            // a sample cut short by the measure bit is dropped, never written in standby
            strobe_q <= tb.sample_tick && next_state != SPM_STANDBY;
            rate_q <= tb.rate_code;
            lowpwr_q <= next_app_rate[RATE_LOWPWR_BIT] && next_state != SPM_STANDBY;
        end
    end

    assign o_reg_rdata = rdata;
    assign o_reg_rvalid = rvalid;
    assign o_sensing_on = sensing_on;
    assign o_sleep = sleep_q;
    assign o_sample_strobe = strobe_q;
    assign o_rate_code = rate_q;
    assign o_low_power = lowpwr_q;

    sequence s_set_measure;
        i_reg_wr && i_reg_addr == ADDR_POWER_CTRL && i_reg_wdata[POW_MEASURE_BIT];
    endsequence

    sequence s_clear_measure;
        i_reg_wr && i_reg_addr == ADDR_POWER_CTRL && !i_reg_wdata[POW_MEASURE_BIT];
    endsequence

    a_measure_entry: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        s_set_measure ##1 !i_reg_wr |=> state != SPM_STANDBY ##1 o_sensing_on)
        else $error("measure bit did not start measuring");

    a_standby_return: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        s_clear_measure |=> ##1 state == SPM_STANDBY && !o_sensing_on)
        else $error("clearing measure bit did not reach standby");

    a_standby_quiet: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        (state == SPM_STANDBY) [*3] |-> !o_sample_strobe && !o_sleep)
        else $error("sample strobe seen in standby");

    a_reg_writable: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        i_reg_wr && i_reg_addr == ADDR_INACT_THR ##1 !i_reg_wr
        ##1 i_reg_rd && i_reg_addr == ADDR_INACT_THR
        |=> o_reg_rvalid && o_reg_rdata == $past(i_reg_wdata, 3))
        else $error("threshold register did not read back");

    a_rate_boundary: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        !$stable(app_rate) |-> $past(tb.sample_tick) || $past(state) == SPM_STANDBY)
        else $error("rate changed inside a sample");

    a_sleep_cause: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        $rose(state == SPM_SLEEP) |-> $past(auto_on && app_period != 8'h00 && tb.sample_tick))
        else $error("sleep entered without quiet timeout");

    a_inact_restart: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        state == SPM_MEASURE && ctl_measure && any_active |=> quiet_secs == 9'd0)
        else $error("active sample did not restart quiet count");

    a_lowpower_off: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        !ctl_measure |=> !o_low_power && !o_sensing_on)
        else $error("low power flagged while not measuring");

    a_lowpower_on: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        state != SPM_STANDBY && ctl_measure && app_rate[RATE_LOWPWR_BIT] && !tb.sample_tick
        |=> o_low_power)
        else $error("low power bit not in force while measuring");

    a_tick_aligned: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        tb.sample_tick |-> tb.base_tick)
        else $error("sample tick off the base tick grid");

    a_sleep_rate: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        state == SPM_SLEEP |=> o_rate_code == SLEEP_RATE_CODE)
        else $error("sleep did not force the slow rate");

    a_wake_activity: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        state == SPM_SLEEP && ctl_measure && any_active |=> state == SPM_MEASURE)
        else $error("active sample did not wake from sleep");

    // period zero or autosleep off must keep the device measuring
    a_no_sleep_off: assert property (@(posedge i_mclk) disable iff (i_sys_rst)
        state == SPM_MEASURE && (!auto_on || app_period == 8'h00) |=> state != SPM_SLEEP)
        else $error("sleep entered with autosleep disabled");
endmodule

// *** test/tb_sensor_power_mode_control.sv ***
/*
 * self-checking bench for the sensor power-mode controller: reset values, register
 * access in standby, rate codes and sample spacing, low power, autosleep and wake.
 * assumes spm_power_ctrl as top with a shortened timebase; the bench plays both the
 * register master and the sensing chain, driving everything at the falling edge.
 */
`timescale 1ns/100ps
module tb_sensor_power_mode_control;
    import spm_pkg::*;
    localparam int TICK = 4;
    localparam int SEC = 3200 * TICK;
    localparam int LIMIT = 90000;
    localparam logic [7:0] THR = 8'h0A;
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [5:0] i_reg_addr = 6'h00;
    logic [7:0] i_reg_wdata = 8'h00;
    logic i_accel_valid = 1'b0;
    logic signed [ACCEL_W-1:0] i_accel_x = '0;
    logic signed [ACCEL_W-1:0] i_accel_y = '0;
    logic signed [ACCEL_W-1:0] i_accel_z = '0;
    logic [7:0] o_reg_rdata;
    logic o_reg_rvalid;
    logic o_sensing_on;
    logic o_sleep;
    logic o_sample_strobe;
    logic [3:0] o_rate_code;
    logic o_low_power;
    logic accel_active = 1'b0;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    int n_strobe = 0;

    spm_power_ctrl #(.P_TICK_3200_CYCLES(TICK)) dut (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_accel_valid(i_accel_valid),
        .i_accel_x(i_accel_x), .i_accel_y(i_accel_y), .i_accel_z(i_accel_z),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid), .o_sensing_on(o_sensing_on),
        .o_sleep(o_sleep), .o_sample_strobe(o_sample_strobe), .o_rate_code(o_rate_code),
        .o_low_power(o_low_power)
    );

    always #2.5 i_mclk = ~i_mclk;

    // quiet values stay inside the threshold after the shift; active ones clear it
    function automatic logic signed [ACCEL_W-1:0] accel_val(input logic act);
        int v;
        v = act ? (176 + int'($urandom_range(500))) : (int'($urandom_range(318)) - 159);
        if (act && $urandom_range(1) == 1) begin
            v = -v;
        end
        return ACCEL_W'(v);
    endfunction

    function automatic int gap_of(input int c);
        return TICK << (15 - ((c < 6) ? 6 : c));
    endfunction

    always @(negedge i_mclk) begin
        i_accel_valid <= (($urandom % 8) == 0);
        i_accel_x <= accel_val(accel_active);
        i_accel_y <= accel_val(1'b0);
        i_accel_z <= accel_val(1'b0);
    end

    task automatic end_sim();
        $display("counts: %0d comparisons, %0d mismatches", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge i_mclk) begin
        cycles++;
        if (o_sample_strobe === 1'b1) begin
            n_strobe++;
        end
        if (cycles == LIMIT) begin
            mismatches++;
            $display("mismatch timeout expected finish seen hang");
            end_sim();
        end
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = d;
        @(negedge i_mclk);
        i_reg_wr = 1'b0;
    endtask

    // rvalid is a one-cycle pulse, so it is looked at in the cycle after the strobe
    task automatic reg_rd(input logic [5:0] a, output logic [7:0] d);
        @(negedge i_mclk);
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        @(negedge i_mclk);
        chk("rvalid", 16'h0001, {15'h0000, o_reg_rvalid});
        d = o_reg_rdata;
        i_reg_rd = 1'b0;
    endtask

    task automatic wait_out(input bit sel_sleep, input logic v, input int lim, output int n);
        n = 0;
        while (((sel_sleep ? o_sleep : o_sensing_on) !== v) && n < lim) begin
            @(negedge i_mclk);
            n++;
        end
        chk(sel_sleep ? "sleep" : "sensing_on", {15'h0000, v},
            {15'h0000, sel_sleep ? o_sleep : o_sensing_on});
    endtask

    task automatic strobe_gap(input int lim, output int g);
        int n;
        n = 0;
        while (o_sample_strobe !== 1'b1 && n < lim) begin
            @(negedge i_mclk);
            n++;
        end
        g = 0;
        do begin
            @(negedge i_mclk);
            g++;
        end while (o_sample_strobe !== 1'b1 && g < lim);
    endtask

    task automatic quiet_strobes(input int len);
        int s;
        s = n_strobe;
        repeat (len) @(negedge i_mclk);
        chk("standby_strobes", 16'h0000, 16'(n_strobe - s));
    endtask

    initial begin
        logic [5:0] addrs [6];
        logic [7:0] exps [6];
        logic [7:0] d;
        logic [31:0] t;
        logic lp;
        int g;
        int n;
        void'($urandom(32'hF8AB));
        addrs = '{ADDR_INACT_THR, ADDR_INACT_PERIOD, ADDR_RATE_CTRL, ADDR_POWER_CTRL,
                  ADDR_MODE_STATUS, 6'h10};
        exps = '{RST_INACT_THR, RST_INACT_PERIOD, 8'h0A, 8'h00, 8'h00, 8'h00};
        repeat (6) @(negedge i_mclk);
        i_sys_rst = 1'b0;
        chk("sensing_on", 16'h0000, {15'h0000, o_sensing_on});
        chk("rate_code", 16'h000A, {12'h000, o_rate_code});
        chk("low_power", 16'h0000, {15'h0000, o_low_power});
        for (int i = 0; i < 6; i++) begin
            reg_rd(addrs[i], d);
            chk("reset_value", {8'h00, exps[i]}, {8'h00, d});
        end
        quiet_strobes(300);
        $display("test reset done");
        // measure kept off so the whole map except the status register is exercised in standby
        repeat (4) begin
            t = $urandom;
            reg_wr(ADDR_INACT_PERIOD, t[15:8]);
            reg_wr(ADDR_RATE_CTRL, t[23:16]);
            reg_wr(ADDR_POWER_CTRL, t[31:24] & 8'h30);
            reg_wr(6'h10, 8'hFF);
            reg_wr(ADDR_INACT_THR, t[7:0]);
            reg_rd(ADDR_INACT_THR, d);
            chk("thr", {8'h00, t[7:0]}, {8'h00, d});
            reg_rd(ADDR_INACT_PERIOD, d);
            chk("period", {8'h00, t[15:8]}, {8'h00, d});
            reg_rd(ADDR_RATE_CTRL, d);
            chk("rate_reg", {8'h00, t[23:16] & 8'h1F}, {8'h00, d});
            reg_rd(ADDR_POWER_CTRL, d);
            chk("power_reg", {8'h00, t[31:24] & 8'h30}, {8'h00, d});
            reg_rd(6'h10, d);
            chk("unmapped", 16'h0000, {8'h00, d});
            chk("sensing_on", 16'h0000, {15'h0000, o_sensing_on});
        end
        reg_wr(ADDR_POWER_CTRL, 8'h00);
        $display("test standby access done");
        for (int c = 5; c <= 15; c++) begin
            lp = (c >= 7 && c <= 12) ? 1'($urandom_range(1)) : 1'b0;
            reg_wr(ADDR_RATE_CTRL, {3'h0, lp, 4'(c)});
            reg_wr(ADDR_POWER_CTRL, 8'h08);
            wait_out(1'b0, 1'b1, 6, n);
            strobe_gap(2 * gap_of(c) + 20, g);
            chk("sample_gap", 16'(gap_of(c)), 16'(g));
            if (c >= 6) begin
                chk("rate_code", 16'(c), {12'h000, o_rate_code});
            end
            chk("low_power", {15'h0000, lp}, {15'h0000, o_low_power});
            reg_wr(ADDR_POWER_CTRL, 8'h00);
            wait_out(1'b0, 1'b0, 6, n);
            chk("low_power_off", 16'h0000, {15'h0000, o_low_power});
            quiet_strobes(gap_of(c) + 20);
        end
        $display("test rate codes done");
        reg_wr(ADDR_INACT_THR, THR);
        reg_wr(ADDR_INACT_PERIOD, 8'h01);
        reg_wr(ADDR_RATE_CTRL, 8'h0A);
        reg_wr(ADDR_POWER_CTRL, 8'h38);
        wait_out(1'b1, 1'b1, SEC + 2000, n);
        chk("sleep_delay", 16'h0001, {15'h0000, 1'(n >= SEC - 300 && n <= SEC + 300)});
        // the rate output follows the mode one cycle later
        @(negedge i_mclk);
        chk("sleep_rate", {12'h000, SLEEP_RATE_CODE}, {12'h000, o_rate_code});
        chk("sleep_sensing", 16'h0001, {15'h0000, o_sensing_on});
        reg_rd(ADDR_MODE_STATUS, d);
        chk("status_sleep", 16'h0002, {14'h0000, d[1:0]});
        accel_active = 1'b1;
        wait_out(1'b1, 1'b0, 150, n);
        @(negedge i_mclk);
        chk("wake_rate", 16'h000A, {12'h000, o_rate_code});
        repeat (200) @(negedge i_mclk);
        accel_active = 1'b0;
        repeat (SEC / 2) @(negedge i_mclk);
        accel_active = 1'b1;
        repeat (60) @(negedge i_mclk);
        accel_active = 1'b0;
        chk("no_early_sleep", 16'h0000, {15'h0000, o_sleep});
        wait_out(1'b1, 1'b1, SEC + 2000, n);
        chk("restart_delay", 16'h0001, {15'h0000, 1'(n >= SEC - 300)});
        reg_wr(ADDR_POWER_CTRL, 8'h00);
        wait_out(1'b0, 1'b0, 6, n);
        chk("sleep_cleared", 16'h0000, {15'h0000, o_sleep});
        quiet_strobes(600);
        $display("test autosleep done");
        end_sim();
    end
endmodule
